// *** port1_data_latch.sv ***
// Purpose: port 1 output latch with pin drive and pin-level readback
// Assumes: crossbar routes each bit via route_en; sfr bus on mclk
// Notes:   open-drain or push-pull per port1_output_mode bit
// Overview of operation
// - written bits latched, driven per crossbar routing
// - latch zero drives a routed pin low
// - latch one open when mode bit zero
// - reads return synchronised pin levels
`timescale 1ns/1ps
`include "port1_map.svh"
module port1_data_latch
   import port1_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   output logic            sfr_hit,
   input  wire logic [7:0] port1_output_mode,
   input  wire logic [7:0] route_en,
   input  wire logic [7:0] port1_data_in,
   output logic      [7:0] port1_data_out,
   output logic      [7:0] port1_data_oe
);
   port_byte_t latch;
   port_byte_t pins_sync;
   logic       sel;

   // per-pin drive enable: a zero is always driven, a one only in
   // push-pull, and nothing leaves a pin the crossbar gave elsewhere
   function automatic port_byte_t drive_enable(
      input port_byte_t lat,
      input port_byte_t mode,
      input port_byte_t route
   );
      drive_enable = route & (~lat | mode);
   endfunction : drive_enable

   // address decode for the single latch register
   assign sel     = (sfr_addr == `PORT1_OUTPUT_LATCH_ADDR);
   assign sfr_hit = sel & (sfr_wr | sfr_rd);

   // output latch written from the bus
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         latch <= `PORT1_OUTPUT_LATCH_RST;
      end else if (sfr_wr && sel) begin
         latch <= sfr_wdata;
      end
   end

   // pin levels pass two flops before any read
   pin_sync #(.WIDTH(`PORT1_WIDTH)) u_sync (
      .mclk     (mclk),
      .nrst     (nrst),
      .async_in (port1_data_in),
      .sync_out (pins_sync)
   );

   // read data registered, cleared to zero when no read; crossbar settings play no part
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd && sel) begin
         sfr_rdata <= pins_sync;
      end else begin
         sfr_rdata <= 8'h00;
      end
   end

   // pin drive: routed zero always driven, routed one driven only in push-pull
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         port1_data_out <= 8'h00;
         port1_data_oe  <= 8'h00;
      end else begin
         port1_data_out <= latch;
         port1_data_oe  <= drive_enable(latch, port1_output_mode,
                                        route_en);
      end
   end

   // pin drive follows the latch one cycle later
   drive_low_a: assert property (@(posedge mclk) disable iff (!nrst)
      (route_en[0] && !latch[0]) |=> (port1_data_oe[0] && !port1_data_out[0]))
      else $error("latch zero not driven low");
   open_high_a: assert property (@(posedge mclk) disable iff (!nrst)
      (latch[0] && !port1_output_mode[0]) |=> !port1_data_oe[0])
      else $error("open-drain one was driven");
   push_high_a: assert property (@(posedge mclk) disable iff (!nrst)
      (route_en[0] && latch[0] && port1_output_mode[0])
      |=> (port1_data_oe[0] && port1_data_out[0]))
      else $error("push-pull one not driven high");
   latch_write_a: assert property (@(posedge mclk) disable iff (!nrst)
      (sfr_wr && sel) |=> (latch == $past(sfr_wdata)))
      else $error("latch did not take write");
   unrouted_a: assert property (@(posedge mclk) disable iff (!nrst)
      !route_en[0] |=> !port1_data_oe[0])
      else $error("unrouted pin driven");
   read_pins_a: assert property (@(posedge mclk) disable iff (!nrst)
      (sfr_rd && sel) |=> (sfr_rdata == $past(pins_sync)))
      else $error("read not pin level");
   read_sync_a: assert property (@(posedge mclk) disable iff (!nrst)
      (sfr_rd && sel && $stable(port1_data_in) && $past(sfr_rd) == 0
       && $stable(pins_sync)) |=> (sfr_rdata == $past(pins_sync)))
      else $error("read data mismatch");
   idle_rdata_a: assert property (@(posedge mclk) disable iff (!nrst)
      !(sfr_rd && sel) |=> (sfr_rdata == 8'h00))
      else $error("read data not cleared");

   // whole-byte checks: every pin, not only bit zero
   low_byte_a: assert property (@(posedge mclk) disable iff (!nrst)
      1'b1 |=> ((~$past(latch) & $past(route_en) & ~port1_data_oe)
                == 8'h00))
      else $error("a routed zero was left undriven");
   open_byte_a: assert property (@(posedge mclk) disable iff (!nrst)
      1'b1 |=> ((port1_data_oe & $past(latch)
                 & ~$past(port1_output_mode)) == 8'h00))
      else $error("an open-drain one was driven");
   out_byte_a: assert property (@(posedge mclk) disable iff (!nrst)
      1'b1 |=> (port1_data_out == $past(latch)))
      else $error("pin value does not follow latch");
   latch_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
      !(sfr_wr && sel) |=> $stable(latch))
      else $error("latch changed without a write");

   // reset values, checked one cycle after reset is sampled low
   reset_drive_a: assert property (@(posedge mclk)
      !nrst |=> (port1_data_oe == 8'h00 && sfr_rdata == 8'h00))
      else $error("outputs not cleared in reset");
   reset_latch_a: assert property (@(posedge mclk)
      !nrst |=> (latch == `PORT1_OUTPUT_LATCH_RST))
      else $error("latch not set to ones in reset");

   write_c:  cover property (@(posedge mclk) disable iff (!nrst) sfr_wr && sel);
   read_c:   cover property (@(posedge mclk) disable iff (!nrst) sfr_rd && sel);
   open_c:   cover property (@(posedge mclk) disable iff (!nrst)
      latch[0] && !port1_output_mode[0]);
   push_c:   cover property (@(posedge mclk) disable iff (!nrst)
      latch[0] && port1_output_mode[0] && route_en[0]);
   low_c:    cover property (@(posedge mclk) disable iff (!nrst)
      !latch[0] && route_en[0]);
endmodule : port1_data_latch

// *** port1_map.svh ***
// Purpose: offsets, reset values and widths for the port 1 data latch
// Assumes: byte-wide special-function-register bus
// Notes:   definitions only
`ifndef PORT1_MAP_SVH
`define PORT1_MAP_SVH
`define PORT1_OUTPUT_LATCH_ADDR 8'h90
`define PORT1_OUTPUT_LATCH_RST  8'hFF
`define PORT1_OUTPUT_MODE_RST   8'h00
`define PORT1_WIDTH             8
`endif

// *** port1_pkg.sv ***
// Purpose: types shared by the port 1 data latch
// Assumes: constants come from port1_map.svh
// Notes:   holds types only
package port1_pkg;
   typedef logic [7:0] port_byte_t;
endpackage : port1_pkg

// *** pin_sync.sv ***
// Purpose: two-flop synchroniser for the port pin levels
// Assumes: pins are asynchronous to mclk
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             mclk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   // two stages, reset to ones to match idle pulled-high pins
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         stage1   <= '1;
         sync_out <= '1;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule : pin_sync

// *** pin_model.sv ***
// Purpose: outside world seen by the port 1 pins
// Assumes: an open pin takes the level set by ext_level
// Notes:   no pull-up is modelled
`timescale 1ns/1ps
module pin_model (
   input  wire logic [7:0] data_out,
   input  wire logic [7:0] data_oe,
   input  wire logic [7:0] ext_level,
   output logic      [7:0] pin_level
);
   // driven bits follow the latch, open bits follow ext_level
   assign pin_level = (data_oe & data_out) | (~data_oe & ext_level);
endmodule : pin_model

// *** port1_data_latch_test.sv ***
// Purpose: self-checking bench for the port 1 data latch
// Assumes: pins come from pin_model, mode fixed at 0x0F
// Notes:   expected drive worked out from latch, mode and route
`timescale 1ns/1ps
`include "port1_map.svh"
module port1_data_latch_test;
   import port1_pkg::*;
   logic       mclk = 0, nrst = 0, wr = 0, rd = 0, hit;
   port_byte_t addr = 0, wdat = 0, rdat, pin, dout, doe;
   port_byte_t mode = 8'h0F, route = 8'hFF, ext = 8'hA5;
   int         num_errors = 0, cmp_count = 0, cyc = 0;
   port1_data_latch i_port1_data_latch (.mclk(mclk), .nrst(nrst),
      .sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wdat),
      .sfr_rdata(rdat), .sfr_hit(hit), .port1_output_mode(mode),
      .route_en(route), .port1_data_in(pin), .port1_data_out(dout),
      .port1_data_oe(doe));
   pin_model i_pin_model (.data_out(dout), .data_oe(doe),
      .ext_level(ext), .pin_level(pin));
   // clock and hang guard
   initial forever #12.5 mclk = ~mclk;
   always @(posedge mclk) if (++cyc == 400) begin
      num_errors++;
      end_sim();
   end
   task automatic chk(string n, port_byte_t e, port_byte_t g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask : chk
   // one bus cycle; read data checked after the taking edge
   task automatic bus(logic w, port_byte_t a, port_byte_t d,
                      port_byte_t r, port_byte_t e);
      @(posedge mclk);
      addr <= a;
      wr <= w;
      rd <= !w;
      wdat <= d;
      route <= r;
      #1 chk("hit", {7'h0, a == `PORT1_OUTPUT_LATCH_ADDR}, {7'h0, hit});
      @(posedge mclk);
      wr <= 0;
      rd <= 0;
      #1 if (!w) chk("rdata", e, rdat);
   endtask : bus
   task automatic drive_ok(port_byte_t l);
      repeat (2) @(posedge mclk);
      #1 chk("out", l, dout);
      chk("oe", route & (~l | mode), doe);
   endtask : drive_ok
   task automatic t_reset();
      #1 chk("oe_rst", 8'h00, doe);
      @(posedge mclk) nrst <= 1;
      drive_ok(`PORT1_OUTPUT_LATCH_RST);
      $display("test reset done");
   endtask : t_reset
   task automatic t_write();
      bus(1, `PORT1_OUTPUT_LATCH_ADDR, 8'h5A, 8'hFF, 0);
      drive_ok(8'h5A);
      bus(1, `PORT1_OUTPUT_LATCH_ADDR, 8'h00, 8'hF0, 0);
      drive_ok(8'h00);
      $display("test write done");
   endtask : t_write
   task automatic t_read();
      repeat (3) @(posedge mclk);
      bus(0, `PORT1_OUTPUT_LATCH_ADDR, 0, 8'hF0, 8'h05);
      bus(0, 8'h91, 0, 8'hF0, 8'h00);
      bus(1, 8'h91, 8'hFF, 8'hF0, 0);
      drive_ok(8'h00);
      $display("test read done");
   endtask : t_read
   task automatic end_sim();
      $display("checks %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_sim
   initial begin
      repeat (2) @(posedge mclk);
      t_reset();
      t_write();
      t_read();
      end_sim();
   end
endmodule : port1_data_latch_test
